/* File: pam4_decode_pkg.sv */
// Shared constants and carrier types for the four-level decode core.
// Assumes one system clock; the serial control port is sampled on it.
package pam4_decode_pkg;

  // ----------------------------------------------------------------
  // Control shift register layout
  // ----------------------------------------------------------------
  localparam int CTRL_BYTES = 5;
  localparam int CTRL_BITS = 40;
  localparam int BOTTOM_LSB = 32; // Byte 1, first in
  localparam int TOP_LSB = 24; // Byte 2
  localparam int DELAY_LSB = 16; // Byte 3
  localparam int SPARE_LSB = 8; // Byte 4, must be zero
  localparam int TAIL_LSB = 0; // Byte 5, low nibble must be zero
  localparam logic [7:0] CODE_RESET = 8'h00;
  localparam logic [5:0] COUNT_RESET = 6'h00;

  // ----------------------------------------------------------------
  // Datapath sizing and timing
  // ----------------------------------------------------------------
  localparam int FIFO_DEPTH = 32;
  localparam int DELAY_DEPTH = 256;
  localparam int CLOCK_PERIOD_NS = 10;

  typedef struct packed {
    logic [7:0] bottom_threshold_code;
    logic [7:0] top_threshold_code;
    logic [7:0] clock_delay_code;
  } control_type;

  typedef struct packed {
    logic top;
    logic middle;
    logic bottom;
  } comparator_type;

  typedef struct packed {
    logic high;
    logic low;
  } symbol_type;

endpackage

/* File: pam4_decode_core_ctrl.sv */
// Decode core and three-wire control port of the four-level decoder.
// Assumes comparator bits, serial pins and out_ready are synchronous to clock;
// one clock cycle stands for one full-rate symbol period.
`timescale 1ns/1ps

// ------------------------------------------------------------------
// Small synchronous FIFO with valid/ready on both sides
// ------------------------------------------------------------------
module sync_fifo #(
  parameter int WIDTH = 2,
  parameter int DEPTH = 32
) (
  input wire logic clock, // System clock
  input wire logic rst_n, // Synchronous reset, active low
  input wire logic [WIDTH-1:0] in_data, // Write data
  input wire logic in_valid, // Write request
  output logic in_ready, // Space available
  output logic [WIDTH-1:0] out_data, // Head entry
  output logic out_valid, // Entry available
  input wire logic out_ready // Consumer takes head
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [AW:0] count_r;
  logic push;
  logic pop;

  // Full and empty come straight from the occupancy count; the depth is
  // compared at the count's own width, since AW bits cannot hold DEPTH
  assign in_ready = (count_r != (AW+1)'(DEPTH));
  assign out_valid = (count_r != '0);
  assign out_data = mem_r[rd_ptr_r];
  assign push = in_valid && in_ready;
  assign pop = out_valid && out_ready;

  // Storage is written only, never reset: content is qualified by count
  always_ff @(posedge clock) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Pointers wrap with the depth, which is a power of two
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      count_r <= '0;
    end else begin
      if (push) begin
        wr_ptr_r <= wr_ptr_r + AW'(1);
      end
      if (pop) begin
        rd_ptr_r <= rd_ptr_r + AW'(1);
      end
      if (push && !pop) begin
        count_r <= count_r + (AW+1)'(1);
      end else if (pop && !push) begin
        count_r <= count_r - (AW+1)'(1);
      end
    end
  end

  // Occupancy stays within the depth; full refuses, any space accepts
  a_fifo_count_bound: assert property (@(posedge clock) disable iff (!rst_n)
    count_r <= (AW+1)'(DEPTH))
    else $error("buffer occupancy above depth");
  a_fifo_full_refuse: assert property (@(posedge clock) disable iff (!rst_n)
    (count_r == (AW+1)'(DEPTH)) |-> !in_ready)
    else $error("full buffer still accepts writes");
  a_fifo_space_ready: assert property (@(posedge clock) disable iff (!rst_n)
    (count_r < (AW+1)'(DEPTH)) |-> in_ready)
    else $error("buffer with space refuses writes");
endmodule

// ------------------------------------------------------------------
// Top: decode datapath and control shift register
// ------------------------------------------------------------------
module pam4_decode_core_ctrl #(
  parameter int DELAY_DEPTH = pam4_decode_pkg::DELAY_DEPTH,
  parameter int FIFO_DEPTH = pam4_decode_pkg::FIFO_DEPTH
) (
  input wire logic clock, // Full-rate clock, one symbol per cycle
  input wire logic rst_n, // Synchronous reset, active low
  input wire pam4_decode_pkg::comparator_type comparator_in, // Thermometer bits
  output logic decode_ready, // Low when the output FIFO is full
  input wire logic out_ready, // Output stage may take a symbol
  output logic data_high_out_pos, // High stream, true
  output logic data_high_out_neg, // High stream, complement
  output logic data_low_out_pos, // Low stream, true
  output logic data_low_out_neg, // Low stream, complement
  output logic half_rate_clock_out_pos, // Divided clock, true
  output logic half_rate_clock_out_neg, // Divided clock, complement
  input wire logic serial_control_write_enable, // Low while shifting
  input wire logic serial_control_clock, // Serial shift clock
  input wire logic serial_control_data_in, // Serial data, MSB first
  output logic serial_control_data_out, // Monitor of register top bit
  output pam4_decode_pkg::control_type control_out, // Applied codes
  output logic control_format_error, // Spare bits were nonzero at apply
  output logic control_load_incomplete // Bit count was not 40 at apply
);
  localparam int DA = $clog2(DELAY_DEPTH);

  typedef enum logic {PORT_IDLE, PORT_SHIFT} port_state_type;

  pam4_decode_pkg::comparator_type delay_line_r [DELAY_DEPTH];
  pam4_decode_pkg::comparator_type retimed_r;
  pam4_decode_pkg::symbol_type decoded;
  pam4_decode_pkg::symbol_type fifo_head;
  pam4_decode_pkg::control_type control_r;
  logic [pam4_decode_pkg::CTRL_BITS-1:0] shift_r;
  logic [5:0] bit_count_r;
  logic sclk_prev_r;
  logic shift_en;
  logic apply_en;
  logic fifo_valid;
  logic pop;
  logic high_r;
  logic low_r;
  logic high_n_r;
  logic low_n_r;
  logic half_r;
  logic half_n_r;
  logic format_err_r;
  logic incomplete_r;
  port_state_type port_state_r;
  port_state_type port_state_nxt;

  // ----------------------------------------------------------------
  // Clock delay and first retime
  // ----------------------------------------------------------------
  // The analog delay is modelled as a tap on a line of samples; a larger
  // code places the latching point later relative to the data.
  always_ff @(posedge clock) begin
    delay_line_r[0] <= comparator_in;
    for (int i = 1; i < DELAY_DEPTH; i++) begin
      delay_line_r[i] <= delay_line_r[i-1];
    end
  end

  // Retime the selected tap before any decoding
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      retimed_r <= '0;
    end else begin
      retimed_r <= delay_line_r[DA'(control_r.clock_delay_code)];
    end
  end

  // ----------------------------------------------------------------
  // Thermometer decode
  // ----------------------------------------------------------------
  // Invalid codes such as top without middle still resolve to a level
  always_comb begin
    decoded.high = retimed_r.middle;
    decoded.low = retimed_r.top | (retimed_r.bottom & ~retimed_r.middle);
  end

  // ----------------------------------------------------------------
  // Output buffering and second retime
  // ----------------------------------------------------------------
  // A symbol arrives every cycle; decode_ready tells the source when it is lost
  sync_fifo #(
    .WIDTH(2),
    .DEPTH(FIFO_DEPTH)
  ) out_fifo (
    .clock(clock),
    .rst_n(rst_n),
    .in_data(decoded),
    .in_valid(1'b1),
    .in_ready(decode_ready),
    .out_data(fifo_head),
    .out_valid(fifo_valid),
    .out_ready(out_ready)
  );

  assign pop = fifo_valid && out_ready;

  // Data and divided clock share one register stage so their edges match
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      high_r <= 1'b0;
      low_r <= 1'b0;
      high_n_r <= 1'b1;
      low_n_r <= 1'b1;
      half_r <= 1'b0;
      half_n_r <= 1'b1;
    end else if (pop) begin
      high_r <= fifo_head.high;
      low_r <= fifo_head.low;
      high_n_r <= ~fifo_head.high;
      low_n_r <= ~fifo_head.low;
      half_r <= ~half_r;
      half_n_r <= half_r;
    end
  end

  assign data_high_out_pos = high_r;
  assign data_high_out_neg = high_n_r;
  assign data_low_out_pos = low_r;
  assign data_low_out_neg = low_n_r;
  assign half_rate_clock_out_pos = half_r;
  assign half_rate_clock_out_neg = half_n_r;

  // ----------------------------------------------------------------
  // Three-wire control port
  // ----------------------------------------------------------------
  // Serial pins are sampled, so the serial clock must be well below clock/2
  assign shift_en = !serial_control_write_enable && serial_control_clock && !sclk_prev_r;
  assign apply_en = (port_state_r == PORT_SHIFT) && serial_control_write_enable;

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      sclk_prev_r <= 1'b0;
    end else begin
      sclk_prev_r <= serial_control_clock;
    end
  end

  // Port state follows the write enable
  always_comb begin
    case (port_state_r)
      PORT_IDLE: port_state_nxt = serial_control_write_enable ? PORT_IDLE : PORT_SHIFT;
      PORT_SHIFT: port_state_nxt = serial_control_write_enable ? PORT_IDLE : PORT_SHIFT;
      default: port_state_nxt = PORT_IDLE;
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      port_state_r <= PORT_IDLE;
    end else begin
      port_state_r <= port_state_nxt;
    end
  end

  // First bit in ends at the top, so byte one lands in the bottom code field
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      shift_r <= '0;
    end else if (shift_en) begin
      shift_r <= {shift_r[pam4_decode_pkg::CTRL_BITS-2:0], serial_control_data_in};
    end
  end

  // Counts bits of one load; saturates so long loads still flag
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      bit_count_r <= pam4_decode_pkg::COUNT_RESET;
    end else if (apply_en) begin
      bit_count_r <= pam4_decode_pkg::COUNT_RESET;
    end else if (shift_en && bit_count_r != 6'h3f) begin
      bit_count_r <= bit_count_r + 6'h01;
    end
  end

  assign serial_control_data_out = shift_r[pam4_decode_pkg::CTRL_BITS-1];

  // Codes change only on release, so half-shifted values never reach the analog side
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      control_r.bottom_threshold_code <= pam4_decode_pkg::CODE_RESET;
      control_r.top_threshold_code <= pam4_decode_pkg::CODE_RESET;
      control_r.clock_delay_code <= pam4_decode_pkg::CODE_RESET;
    end else if (apply_en) begin
      control_r.bottom_threshold_code <= shift_r[pam4_decode_pkg::BOTTOM_LSB +: 8];
      control_r.top_threshold_code <= shift_r[pam4_decode_pkg::TOP_LSB +: 8];
      control_r.clock_delay_code <= shift_r[pam4_decode_pkg::DELAY_LSB +: 8];
    end
  end

  // Status of the last applied load
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      format_err_r <= 1'b0;
      incomplete_r <= 1'b0;
    end else if (apply_en) begin
      format_err_r <= (shift_r[pam4_decode_pkg::SPARE_LSB +: 8] != 8'h00) ||
                      (shift_r[pam4_decode_pkg::TAIL_LSB +: 4] != 4'h0);
      incomplete_r <= (bit_count_r != 6'h28);
    end
  end

  assign control_out = control_r;
  assign control_format_error = format_err_r;
  assign control_load_incomplete = incomplete_r;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);

  a_retime_tap_select: assert property ($stable(control_r.clock_delay_code) |=>
    retimed_r == $past(delay_line_r[DA'(control_r.clock_delay_code)]))
    else $error("retimed sample not taken from selected tap");
  a_decode_high_map: assert property (out_fifo.push |->
    out_fifo.in_data[1] == retimed_r.middle)
    else $error("high stream does not follow middle bit");
  a_decode_low_map: assert property (out_fifo.push |->
    out_fifo.in_data[0] == (retimed_r.top | (retimed_r.bottom & ~retimed_r.middle)))
    else $error("low stream decode wrong");
  a_output_data_retime: assert property (pop |=>
    {high_r, low_r} == $past(fifo_head) && high_n_r == ~high_r && low_n_r == ~low_r)
    else $error("output data not registered from FIFO head");
  a_half_rate_toggle: assert property (pop |=> half_r != $past(half_r) && half_n_r == ~half_r)
    else $error("half-rate clock did not toggle with data");
  a_outputs_hold_aligned: assert property (!pop |=> $stable(half_r) && $stable(high_r) && $stable(low_r))
    else $error("output changed without a symbol");
  a_serial_shift_step: assert property (shift_en |=>
    shift_r == {$past(shift_r[pam4_decode_pkg::CTRL_BITS-2:0]), $past(serial_control_data_in)})
    else $error("serial shift wrong");
  a_serial_shift_hold: assert property (!shift_en |=> $stable(shift_r))
    else $error("shift register moved without serial edge");
  a_serial_monitor_out: assert property (shift_en |=>
    serial_control_data_out == $past(shift_r[pam4_decode_pkg::CTRL_BITS-2]))
    else $error("serial monitor not showing shifted bit");
  a_apply_on_release: assert property ($rose(serial_control_write_enable) && port_state_r == PORT_SHIFT |=>
    control_r == $past(shift_r[pam4_decode_pkg::CTRL_BITS-1:pam4_decode_pkg::DELAY_LSB]))
    else $error("codes not applied on enable release");
  a_codes_hold_shift: assert property (!serial_control_write_enable |=> $stable(control_r))
    else $error("codes changed while shifting");

  c_symbol_out: cover property (pop ##1 pop);
  c_control_apply: cover property (apply_en && !incomplete_r);
  c_fifo_full: cover property (!decode_ready);
  c_format_error: cover property (apply_en ##1 control_format_error);
endmodule

/* File: serial_controller_model.sv */
// Behavioural model of the controller that loads the three-wire control port.
// Assumes the bench raises start for one clock while busy is low.
`timescale 1ns/1ps

module serial_controller_model (
  input wire logic clock, // System clock
  input wire logic start, // Begin one frame
  input wire logic [39:0] word, // Frame contents, bit 39 goes first
  input wire logic [5:0] bit_count, // Bits to send, short counts make a bad frame
  input wire logic slow, // Stretch each serial clock phase
  output logic busy, // Frame in progress
  output logic serial_control_write_enable, // Low while shifting
  output logic serial_control_clock, // Serial shift clock
  output logic serial_control_data_in // Serial data
);
  int hold;

  initial begin
    busy = 1'b0;
    serial_control_write_enable = 1'b1;
    serial_control_clock = 1'b0;
    serial_control_data_in = 1'b0;
  end

  // ----------------------------------------------------------------
  // Frame: enable low, low then high clock phase per bit, enable high
  // ----------------------------------------------------------------
  // The serial clock stays low outside frames; the released data line shows the
  // inverse of its last bit so a core that samples late cannot match by luck.
  always @(posedge clock) begin
    if (start && !busy) begin
      hold = slow ? 5 : 2;
      busy <= 1'b1;
      serial_control_write_enable <= 1'b0;
      for (int i = 0; i < bit_count; i++) begin
        serial_control_clock <= 1'b0;
        serial_control_data_in <= word[39 - i];
        repeat (hold) @(posedge clock);
        serial_control_clock <= 1'b1;
        repeat (hold) @(posedge clock);
      end
      serial_control_clock <= 1'b0;
      serial_control_data_in <= ~serial_control_data_in;
      repeat (hold) @(posedge clock);
      serial_control_write_enable <= 1'b1;
      busy <= 1'b0;
    end
  end
endmodule

/* File: tb.sv */
// Self-checking bench for the decode core and its three-wire control port.
// Assumes serial_controller_model drives the port; delay depth is cut to 16.
`timescale 1ns/1ps

module tb;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  pam4_decode_pkg::comparator_type comp = 3'h0;
  logic out_ready = 1'b1;
  logic start = 1'b0;
  logic slow = 1'b0;
  logic [39:0] word = 40'h0;
  logic [5:0] nbits = 6'h28;
  logic busy, wen, sclk, sdin, sdout, dec_rdy, hp, hn, lp, ln, cp, cn, fmt_err, incomplete;
  pam4_decode_pkg::control_type ctrl;
  int error_cnt = 0;
  int checks_done = 0;
  int seed = 19136;
  int cyc = 0;
  int sync_time = 0;
  int drive_time = 0;
  int lat0 = 0;
  bit track = 0;
  bit synced = 0;
  logic last_half = 1'b0;
  logic [1:0] expq[$];

  always #5 clock = ~clock;
  always @(posedge clock) cyc <= cyc + 1;

  serial_controller_model ctl (.clock(clock), .start(start), .word(word), .bit_count(nbits), .slow(slow),
    .busy(busy), .serial_control_write_enable(wen), .serial_control_clock(sclk), .serial_control_data_in(sdin));

  pam4_decode_core_ctrl #(.DELAY_DEPTH(16), .FIFO_DEPTH(32)) dut (.clock(clock), .rst_n(rst_n),
    .comparator_in(comp), .decode_ready(dec_rdy), .out_ready(out_ready), .data_high_out_pos(hp),
    .data_high_out_neg(hn), .data_low_out_pos(lp), .data_low_out_neg(ln), .half_rate_clock_out_pos(cp),
    .half_rate_clock_out_neg(cn), .serial_control_write_enable(wen), .serial_control_clock(sclk),
    .serial_control_data_in(sdin), .serial_control_data_out(sdout), .control_out(ctrl),
    .control_format_error(fmt_err), .control_load_incomplete(incomplete));

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  task automatic check(input logic [39:0] got, input logic [39:0] exp);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  function automatic logic [1:0] decode(input pam4_decode_pkg::comparator_type c);
    return {c.middle, c.top | (c.bottom & ~c.middle)};
  endfunction

  // Extra edge before polling busy, so the model's own update has landed
  task automatic load(input logic [39:0] w, input logic [5:0] n);
    int k;
    k = 0;
    word <= w;
    nbits <= n;
    start <= 1'b1;
    @(posedge clock);
    start <= 1'b0;
    @(posedge clock);
    while (busy !== 1'b0 && k < 2000) begin
      @(posedge clock);
      k++;
    end
    repeat (3) @(posedge clock);
  endtask

  task automatic print_verdict();
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Output monitor: complements, one toggle per symbol, symbols in order
  always @(negedge clock) begin
    if (rst_n === 1'b1) begin
      check({hn, ln, cn} ^ {hp, lp, cp}, 3'b111);
      if (track && synced) check(40'(cp !== last_half), 40'h1);
      if (cp !== last_half && track) begin
        if (!synced && {hp, lp} !== 2'b00) begin
          synced = 1;
          sync_time = cyc;
        end
        if (synced && expq.size() > 0) check({hp, lp}, expq.pop_front());
      end
      last_half = cp;
    end
  end

  // Watchdog sized well above the expected few thousand cycles
  initial begin
    repeat (40000) @(posedge clock);
    error_cnt++;
    print_verdict();
  end

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] b, t, d;
    logic h;
    pam4_decode_pkg::comparator_type c;
    repeat (4) @(posedge clock);
    check({hp, hn, lp, ln, cp, cn, sdout, dec_rdy, fmt_err, incomplete}, 10'h154);
    check({16'h0, ctrl}, 40'h0);
    rst_n <= 1'b1;
    $display("test reset done");
    // Loads: first one has the don't-care nibble set, a full-scale bottom code and a mid-scale top code
    for (int i = 0; i < 5; i++) begin
      b = (i == 0) ? 8'hff : 8'($random(seed));
      t = (i == 0) ? 8'h80 : 8'($random(seed));
      d = 8'($random(seed)) & 8'h0f;
      slow <= i[0];
      load({b, t, d, 8'h00, (i == 0) ? 8'hf0 : 8'h00}, 6'h28);
      check({16'h0, ctrl}, {16'h0, b, t, d});
      check({fmt_err, incomplete, sdout}, {2'b00, b[7]});
    end
    $display("test load done");
    load({24'h010203, 8'h01, 8'h00}, 6'h28);
    check(fmt_err, 1'b1);
    load({24'h010203, 8'h00, 8'h08}, 6'h28);
    check(fmt_err, 1'b1);
    load(40'h0, 6'h27);
    check(incomplete, 1'b1);
    load({24'h010203, 16'h0000}, 6'h28);
    check({fmt_err, incomplete}, 2'b00);
    $display("test format done");
    // Stream at delay codes 0 and 7; latency must grow by exactly 7
    for (int j = 0; j < 2; j++) begin
      load({16'h40c0, 8'(j * 7), 16'h0000}, 6'h28);
      comp <= 3'h0;
      repeat (30) @(posedge clock);
      synced = 0;
      expq.delete();
      track = 1;
      for (int k = 0; k < 80; k++) begin
        c = (k == 0) ? 3'b111 : ((k < 60) ? 3'($random(seed)) : 3'b000);
        comp <= c;
        expq.push_back(decode(c));
        if (k == 0) drive_time = cyc;
        @(posedge clock);
      end
      track = 0;
      check({38'h0, synced, 1'(expq.size() < 12)}, 40'h3);
      if (j == 0) lat0 = sync_time - drive_time;
      else check(40'(sync_time - drive_time - lat0), 40'h7);
    end
    $display("test decode done");
    // Stall the output side until the buffer refuses, then release it until it accepts again
    out_ready <= 1'b0;
    repeat (3) @(posedge clock);
    h = cp;
    repeat (40) begin
      comp <= 3'($random(seed));
      @(posedge clock);
    end
    check({dec_rdy, cp}, {1'b0, h});
    out_ready <= 1'b1;
    repeat (40) @(posedge clock);
    check(dec_rdy, 1'b1);
    $display("test stall done");
    print_verdict();
  end
endmodule
